// ### core/rsf_consts.vh
// Constants for the register, stack and flag execution block.
`ifndef RSF_CONSTS_VH
`define RSF_CONSTS_VH
// Six-bit single-register opcodes, taken from opcode bits 7..2.
`define RSF_OP_SHR 6'h3b
`define RSF_OP_PUSH 6'h33
`define RSF_OP_PULL 6'h36
`define RSF_OP_SWAP_REG_STACK_OP 6'h32
`define RSF_OP_LDI 6'h08
`define RSF_OP_ADSZ 6'h0c
`define RSF_OP_NEG 6'h37
// Four-bit register-to-register opcodes, taken from opcode bits 7..4.
`define RSF_OP_REG_ADD_OP 4'h4
`define RSF_OP_REG_XOR_OP 4'h5
`define RSF_OP_RSWP 4'h6
`define RSF_OP_REG_AND_OP 4'h7
// Whole-byte opcodes.
`define RSF_OP_HALT 8'h00
`define RSF_OP_SAVF 8'h07
`define RSF_OP_RSTF 8'h0e
// Five-bit control flag opcodes, taken from opcode bits 7..3.
`define RSF_OP_SETF 5'h05
`define RSF_OP_PULF 5'h07
// Status flag byte field positions.
`define RSF_ST_EXT 7
`define RSF_ST_WRAP 6
`define RSF_ST_CARRY 5
// Control flag codes.
`define RSF_FC_USER_LO 3'h1
`define RSF_FC_USER_HI 3'h4
`define RSF_FC_SEL 3'h6
`define RSF_FC_INTERRUPT_ENABLE_FLAG 3'h7
// Microcycle phases, counted 1 to 8.
`define RSF_PHASES 4'h8
`define RSF_PH_PULSE_ON 4'h2
`define RSF_PH_PULSE_OFF 4'h6
// Reset values.
`define RSF_RST_STATUS 8'h00
`define RSF_RST_CTL 6'h00
`endif

// ### core/rsf_phase_gen.v
// Microcycle phase counter producing phase numbers 1 to 8.
`timescale 1ns/1ps
`include "rsf_consts.vh"
module rsf_phase_gen (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Phase outputs.
   output reg [3:0] phase_q,
   output reg cycle_end_q
);
   reg [3:0] phase_d;
   always @* begin
      if (phase_q == `RSF_PHASES) begin
         phase_d = 4'h1;
      end else begin
         phase_d = phase_q + 4'h1;
      end
   end
   always @(posedge clk) begin
      if (!rst_b) begin
         phase_q <= 4'h1;
         cycle_end_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cycle_end_q <= (phase_d == `RSF_PHASES);
      end
   end
endmodule

// ### core/rsf_exec.v
// Register, stack and flag instruction execution unit.
`timescale 1ns/1ps
`include "rsf_consts.vh"
// Summary of operation
// - Plain shift right loads zero into bit seven.
// - Extended shift uses extension bit, then clears it.
// - Push copies accumulator down; deepest level lost.
// - Pull loads accumulator, stack up, zero fill.
// - Swap stack top with selected accumulator only.
// - Load immediate overwrites accumulator with operand.
// - Add immediate; zero result requests a skip.
// - Negate replaces accumulator with two's complement.
// - Register add writes destination, sets wrap, carry.
// - Register swap exchanges source and destination.
// - Register xor writes result into destination.
// - Register and writes result into destination.
// - Halt opcode stops until start input falls.
// - Save flags pushes status byte onto stack.
// - Restore flags pulls status byte, zero fill.
// - Status byte: ext, wrap, carry, general flags.
// - Additions set carry and wrap from result.
// - Control flag ops use five-bit opcode, code.
// - Pulse raises flag at phase two, drops six.
// - Set makes selected control flag active.
module rsf_exec #(
   parameter STACK_DEPTH = 16
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Instruction from the sequencer.
   input wire instr_valid,
   input wire [7:0] opcode,
   input wire [7:0] imm_data,
   // Start input.
   input wire start_in,
   // Execution status.
   output reg instr_done_q,
   output reg skip_next_q,
   output reg halted_q,
   // Accumulator zero for observation.
   output reg [7:0] acc0_q,
   // Status flags and stack top.
   output reg [7:0] status_q,
   output reg [7:0] stack_top_q,
   // Control flags.
   output reg shift_via_ext_q,
   output reg interrupt_enable_flag_q,
   output reg [3:0] user_flags_q
);
   // ****************************************
   // Storage and decode
   // ****************************************
   reg [7:0] acc_q [0:3];
   reg [7:0] stk_q [0:STACK_DEPTH-1];
   reg busy_q;
   reg [7:0] op_q;
   reg [7:0] imm_q;
   reg start_prev_q;
   reg pulse_on_q;
   reg [2:0] pulse_code_q;
   wire [3:0] phase;
   wire cycle_end;
   integer i;

   rsf_phase_gen u_phase (
      .clk(clk),
      .rst_b(rst_b),
      .phase_q(phase),
      .cycle_end_q(cycle_end)
   );

   // Selects one accumulator by its two-bit number.
   function [7:0] acc_sel;
      input [1:0] n;
      input [7:0] a0;
      input [7:0] a1;
      input [7:0] a2;
      input [7:0] a3;
      begin
         case (n)
            2'h0: acc_sel = a0;
            2'h1: acc_sel = a1;
            2'h2: acc_sel = a2;
            default: acc_sel = a3;
         endcase
      end
   endfunction

   // Instruction classes, one binary code for each decoded operation.
   localparam [3:0] CL_NONE = 4'b0000;
   localparam [3:0] CL_SHR = 4'b0001;
   localparam [3:0] CL_PUSH = 4'b0010;
   localparam [3:0] CL_PULL = 4'b0011;
   localparam [3:0] CL_SWAP_REG_STACK_OP = 4'b0100;
   localparam [3:0] CL_LDI = 4'b0101;
   localparam [3:0] CL_ADSZ = 4'b0110;
   localparam [3:0] CL_NEG = 4'b0111;
   localparam [3:0] CL_REG_ADD_OP = 4'b1000;
   localparam [3:0] CL_RSWP = 4'b1001;
   localparam [3:0] CL_REG_XOR_OP = 4'b1010;
   localparam [3:0] CL_REG_AND_OP = 4'b1011;
   localparam [3:0] CL_SAVF = 4'b1100;
   localparam [3:0] CL_RSTF = 4'b1101;
   localparam [3:0] CL_SETF = 4'b1110;
   localparam [3:0] CL_PULF = 4'b1111;

   // Sorts an opcode byte into its instruction class; halt and unknown codes give none.
   function [3:0] op_class;
      input [7:0] op;
      begin
         if (op == `RSF_OP_SAVF) begin
            op_class = CL_SAVF;
         end else if (op == `RSF_OP_RSTF) begin
            op_class = CL_RSTF;
         end else if (op[7:2] == `RSF_OP_SHR) begin
            op_class = CL_SHR;
         end else if (op[7:2] == `RSF_OP_PUSH) begin
            op_class = CL_PUSH;
         end else if (op[7:2] == `RSF_OP_PULL) begin
            op_class = CL_PULL;
         end else if (op[7:2] == `RSF_OP_SWAP_REG_STACK_OP) begin
            op_class = CL_SWAP_REG_STACK_OP;
         end else if (op[7:2] == `RSF_OP_LDI) begin
            op_class = CL_LDI;
         end else if (op[7:2] == `RSF_OP_ADSZ) begin
            op_class = CL_ADSZ;
         end else if (op[7:2] == `RSF_OP_NEG) begin
            op_class = CL_NEG;
         end else if (op[7:3] == `RSF_OP_SETF) begin
            op_class = CL_SETF;
         end else if (op[7:3] == `RSF_OP_PULF) begin
            op_class = CL_PULF;
         end else if (op[7:4] == `RSF_OP_REG_ADD_OP) begin
            op_class = CL_REG_ADD_OP;
         end else if (op[7:4] == `RSF_OP_RSWP) begin
            op_class = CL_RSWP;
         end else if (op[7:4] == `RSF_OP_REG_XOR_OP) begin
            op_class = CL_REG_XOR_OP;
         end else if (op[7:4] == `RSF_OP_REG_AND_OP) begin
            op_class = CL_REG_AND_OP;
         end else begin
            op_class = CL_NONE;
         end
      end
   endfunction

   wire [1:0] reg_r = op_q[1:0];
   wire [1:0] reg_s = op_q[3:2];
   wire [1:0] reg_d = op_q[1:0];
   wire [7:0] val_r = acc_sel(reg_r, acc_q[0], acc_q[1], acc_q[2], acc_q[3]);
   wire [7:0] val_s = acc_sel(reg_s, acc_q[0], acc_q[1], acc_q[2], acc_q[3]);
   wire [7:0] val_d = acc_sel(reg_d, acc_q[0], acc_q[1], acc_q[2], acc_q[3]);
   wire [3:0] cls = op_class(op_q);
   wire [8:0] sum_imm = {1'b0, val_r} + {1'b0, imm_q};
   wire [8:0] sum_reg = {1'b0, val_s} + {1'b0, val_d};
   wire [7:0] neg_r = (~val_r) + 8'h01;
   wire wrap_reg = (val_s[7] == val_d[7]) && (sum_reg[7] != val_d[7]);
   wire wrap_imm = (val_r[7] == imm_q[7]) && (sum_imm[7] != val_r[7]);

   // ****************************************
   // Instruction capture and halt
   // ****************************************
   always @(posedge clk) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         op_q <= 8'h00;
         imm_q <= 8'h00;
         halted_q <= 1'b0;
         start_prev_q <= 1'b0;
         instr_done_q <= 1'b0;
      end else begin
         start_prev_q <= start_in;
         instr_done_q <= 1'b0;
         if (halted_q) begin
            if (start_prev_q && !start_in) begin
               halted_q <= 1'b0;
               instr_done_q <= 1'b1;
            end
         end else if (!busy_q) begin
            if (instr_valid) begin
               busy_q <= 1'b1;
               op_q <= opcode;
               imm_q <= imm_data;
            end
         end else if (cycle_end) begin
            busy_q <= 1'b0;
            if (op_q == `RSF_OP_HALT) begin
               halted_q <= 1'b1;
            end else begin
               instr_done_q <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Accumulators, stack and status flags
   // ****************************************
   wire exec = busy_q && cycle_end;
   always @(posedge clk) begin
      if (!rst_b) begin
         for (i = 0; i < 4; i = i + 1) begin
            acc_q[i] <= 8'h00;
         end
         status_q <= `RSF_RST_STATUS;
         skip_next_q <= 1'b0;
      end else begin
         skip_next_q <= 1'b0;
         if (exec) begin
            case (cls)
               CL_SHR: begin
                  if (shift_via_ext_q) begin
                     acc_q[reg_r] <= {status_q[`RSF_ST_EXT], val_r[7:1]};
                     status_q[`RSF_ST_EXT] <= 1'b0;
                  end else begin
                     acc_q[reg_r] <= {1'b0, val_r[7:1]};
                  end
               end
               CL_PULL: begin
                  acc_q[reg_r] <= stk_q[0];
               end
               CL_SWAP_REG_STACK_OP: begin
                  acc_q[reg_r] <= stk_q[0];
               end
               CL_LDI: begin
                  acc_q[reg_r] <= imm_q;
               end
               CL_ADSZ: begin
                  acc_q[reg_r] <= sum_imm[7:0];
                  skip_next_q <= (sum_imm[7:0] == 8'h00);
                  status_q[`RSF_ST_CARRY] <= sum_imm[8];
                  status_q[`RSF_ST_WRAP] <= wrap_imm;
               end
               CL_NEG: begin
                  acc_q[reg_r] <= neg_r;
               end
               CL_REG_ADD_OP: begin
                  acc_q[reg_d] <= sum_reg[7:0];
                  status_q[`RSF_ST_CARRY] <= sum_reg[8];
                  status_q[`RSF_ST_WRAP] <= wrap_reg;
               end
               CL_RSWP: begin
                  acc_q[reg_s] <= val_d;
                  acc_q[reg_d] <= val_s;
               end
               CL_REG_XOR_OP: begin
                  acc_q[reg_d] <= val_d ^ val_s;
               end
               CL_REG_AND_OP: begin
                  acc_q[reg_d] <= val_d & val_s;
               end
               CL_RSTF: begin
                  status_q <= stk_q[0];
               end
               default: begin
                  skip_next_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Hardware stack
   // ****************************************
   wire stk_push = exec && ((cls == CL_PUSH) || (cls == CL_SAVF));
   wire stk_pull = exec && ((cls == CL_PULL) || (cls == CL_RSTF));
   wire stk_swap = exec && (cls == CL_SWAP_REG_STACK_OP);
   wire [7:0] stk_in = (cls == CL_SAVF) ? status_q : val_r;
   always @(posedge clk) begin
      if (!rst_b) begin
         for (i = 0; i < STACK_DEPTH; i = i + 1) begin
            stk_q[i] <= 8'h00;
         end
      end else if (stk_push) begin
         stk_q[0] <= stk_in;
         for (i = 1; i < STACK_DEPTH; i = i + 1) begin
            stk_q[i] <= stk_q[i-1];
         end
      end else if (stk_pull) begin
         for (i = 0; i < STACK_DEPTH - 1; i = i + 1) begin
            stk_q[i] <= stk_q[i+1];
         end
         stk_q[STACK_DEPTH-1] <= 8'h00;
      end else if (stk_swap) begin
         stk_q[0] <= val_r;
      end
   end

   // ****************************************
   // Control flags
   // ****************************************
   // Turns a control flag code into a one-hot select; codes 0 and 5 select nothing.
   function [7:0] flag_hot;
      input [2:0] code;
      begin
         flag_hot = 8'h00;
         if ((code == `RSF_FC_SEL) || (code == `RSF_FC_INTERRUPT_ENABLE_FLAG) ||
             ((code >= `RSF_FC_USER_LO) && (code <= `RSF_FC_USER_HI))) begin
            flag_hot[code] = 1'b1;
         end
      end
   endfunction

   wire ctl_set = busy_q && (cls == CL_SETF) && (phase == `RSF_PH_PULSE_ON);
   wire ctl_pulse = busy_q && (cls == CL_PULF) && (phase == `RSF_PH_PULSE_ON);
   wire [7:0] set_hot = flag_hot(op_q[2:0]);
   wire [7:0] clr_hot = flag_hot(pulse_code_q);

   always @(posedge clk) begin
      if (!rst_b) begin
         {shift_via_ext_q, interrupt_enable_flag_q, user_flags_q} <= `RSF_RST_CTL;
         pulse_on_q <= 1'b0;
         pulse_code_q <= 3'h0;
      end else begin
         if (ctl_set || ctl_pulse) begin
            shift_via_ext_q <= shift_via_ext_q | set_hot[`RSF_FC_SEL];
            interrupt_enable_flag_q <= interrupt_enable_flag_q | set_hot[`RSF_FC_INTERRUPT_ENABLE_FLAG];
            user_flags_q <= user_flags_q | set_hot[4:1];
            pulse_on_q <= ctl_pulse;
            pulse_code_q <= op_q[2:0];
         end else if (pulse_on_q && (phase == `RSF_PH_PULSE_OFF)) begin
            pulse_on_q <= 1'b0;
            shift_via_ext_q <= shift_via_ext_q & ~clr_hot[`RSF_FC_SEL];
            interrupt_enable_flag_q <= interrupt_enable_flag_q & ~clr_hot[`RSF_FC_INTERRUPT_ENABLE_FLAG];
            user_flags_q <= user_flags_q & ~clr_hot[4:1];
         end
      end
   end

   // ****************************************
   // Observation outputs
   // ****************************************
   always @(posedge clk) begin
      if (!rst_b) begin
         acc0_q <= 8'h00;
         stack_top_q <= 8'h00;
      end else begin
         acc0_q <= acc_q[0];
         stack_top_q <= stk_q[0];
      end
   end
endmodule

// ### verification/rsf_seq_model.sv
// Sequencer model that offers one instruction at a time to the block.
`timescale 1ns/1ps
module rsf_seq_model (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Command from the bench.
   input wire cmd_ok,
   input wire [7:0] cmd_op,
   input wire [7:0] cmd_imm,
   // Block side.
   input wire instr_done_q,
   output wire instr_valid,
   output wire [7:0] opcode,
   output wire [7:0] imm_data
);
   reg busy_q;
   assign instr_valid = cmd_ok && (!busy_q || instr_done_q);
   assign opcode = instr_valid ? cmd_op : ~cmd_op;
   assign imm_data = instr_valid ? cmd_imm : ~cmd_imm;
   always @(posedge clk) begin
      if (!rst_b || instr_valid) busy_q <= rst_b;
      else if (instr_done_q) busy_q <= 1'b0;
   end
endmodule

// ### verification/rsf_exec_props.sv
// Checker for the register, stack and flag execution block.
`timescale 1ns/1ps
`include "rsf_consts.vh"
module rsf_exec_props #(
   parameter STACK_DEPTH = 16
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Inputs.
   input wire instr_valid,
   input wire [7:0] opcode,
   input wire [7:0] imm_data,
   input wire start_in,
   // Outputs.
   input wire instr_done_q,
   input wire skip_next_q,
   input wire halted_q,
   input wire [7:0] acc0_q,
   input wire [7:0] status_q,
   input wire [7:0] stack_top_q,
   input wire shift_via_ext_q,
   input wire interrupt_enable_flag_q,
   input wire [3:0] user_flags_q
);
   reg busy_q;
   reg [7:0] op_q;
   wire [3:0] pmask = 4'h1 << (op_q[2:0] - 3'h1);
   wire pulse_op = busy_q && op_q[7:3] == `RSF_OP_PULF;
   always @(posedge clk) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         op_q <= 8'h00;
      end else if (instr_valid && (!busy_q || instr_done_q)) begin
         busy_q <= 1'b1;
         op_q <= opcode;
      end else if (instr_done_q) begin
         busy_q <= 1'b0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_up;
      pulse_op && (user_flags_q & pmask) != 4'h0 && ($past(user_flags_q) & pmask) == 4'h0;
   endsequence
   sequence s_down;
      ((user_flags_q & pmask) != 4'h0) [*3] ##1 ((user_flags_q & pmask) == 4'h0);
   endsequence
   AST_PULSE_SHAPE: assert property (s_up |=> s_down)
      else $error("pulse width wrong");
   AST_SKIP_DONE: assert property (skip_next_q |-> instr_done_q)
      else $error("skip without done");
   AST_SKIP_ADD: assert property (instr_done_q && op_q[7:2] != `RSF_OP_ADSZ |-> !skip_next_q)
      else $error("skip on other op");
   AST_HALT_ENTRY: assert property ($rose(halted_q) |-> op_q == `RSF_OP_HALT)
      else $error("halt without halt op");
   AST_HALT_STAY: assert property (halted_q && !start_in && !$past(start_in) && !$past(start_in, 2) |=> halted_q)
      else $error("halt left early");
   AST_HALT_EXIT: assert property (halted_q && $fell(start_in) |-> ##[1:2] (instr_done_q && !halted_q))
      else $error("halt not released");
   AST_ACC_LAG: assert property (!$stable(acc0_q) |-> $past(instr_done_q))
      else $error("acc changed off commit");
   AST_STK_LAG: assert property (!$stable(stack_top_q) |-> $past(instr_done_q))
      else $error("stack changed off commit");
   AST_SEL_KEEP: assert property (shift_via_ext_q && !pulse_op |=> shift_via_ext_q)
      else $error("select flag lost");
endmodule
bind rsf_exec rsf_exec_props #(.STACK_DEPTH(STACK_DEPTH)) u_rsf_exec_props (.clk(clk), .rst_b(rst_b),
   .instr_valid(instr_valid), .opcode(opcode), .imm_data(imm_data), .start_in(start_in),
   .instr_done_q(instr_done_q), .skip_next_q(skip_next_q), .halted_q(halted_q), .acc0_q(acc0_q),
   .status_q(status_q), .stack_top_q(stack_top_q), .shift_via_ext_q(shift_via_ext_q),
   .interrupt_enable_flag_q(interrupt_enable_flag_q), .user_flags_q(user_flags_q));

// ### verification/rsf_exec_bench.sv
// Self-checking bench for the register, stack and flag execution block.
`timescale 1ns/1ps
module rsf_exec_bench;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg start_in = 1'b0;
   reg cmd_ok = 1'b0;
   reg [7:0] cmd_op = 8'h00;
   reg [7:0] cmd_imm = 8'h00;
   wire instr_valid, instr_done_q, skip_next_q, halted_q, shift_via_ext_q, interrupt_enable_flag_q;
   wire [7:0] opcode, imm_data, acc0_q, status_q, stack_top_q;
   wire [3:0] user_flags_q;
   reg [46:0] rows [0:21];
   reg [3:0] hi_seen, m, b;
   reg skip_seen;
   integer failures = 0;
   integer cmp_count = 0;
   integer i;
   always #10 clk = ~clk;
   rsf_seq_model u_rsf_seq_model (.clk(clk), .rst_b(rst_b), .cmd_ok(cmd_ok), .cmd_op(cmd_op),
      .cmd_imm(cmd_imm), .instr_done_q(instr_done_q), .instr_valid(instr_valid), .opcode(opcode),
      .imm_data(imm_data));
   rsf_exec #(.STACK_DEPTH(4)) u_rsf_exec (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
      .opcode(opcode), .imm_data(imm_data), .start_in(start_in), .instr_done_q(instr_done_q),
      .skip_next_q(skip_next_q), .halted_q(halted_q), .acc0_q(acc0_q), .status_q(status_q),
      .stack_top_q(stack_top_q), .shift_via_ext_q(shift_via_ext_q),
      .interrupt_enable_flag_q(interrupt_enable_flag_q), .user_flags_q(user_flags_q));
   task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task issue(input [7:0] op, input [7:0] im);
      integer n;
      begin
         if (!clk) @(posedge clk);
         cmd_ok <= 1'b1;
         cmd_op <= op;
         cmd_imm <= im;
         n = 0;
         @(negedge clk);
         while (instr_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n = n + 1;
         end
         @(posedge clk);
         if (n == 40) failures = failures + 1;
      end
   endtask
   task drain;
      integer n;
      begin
         cmd_ok <= 1'b0;
         n = 0;
         hi_seen = 4'h0;
         @(negedge clk);
         while (instr_done_q !== 1'b1 && n < 40) begin
            hi_seen = hi_seen | user_flags_q;
            @(negedge clk);
            n = n + 1;
         end
         skip_seen = skip_next_q;
         if (n == 40) failures = failures + 1;
         @(negedge clk);
      end
   endtask
   task end_sim;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (6000) @(posedge clk);
      failures = failures + 1;
      end_sim;
   end
   initial begin
      rows[0] = {8'h20, 8'h81, 8'h81, 8'h00, 8'h00, 1'h0, 6'h00};
      rows[1] = {8'hEC, 8'h00, 8'h40, 8'h00, 8'h00, 1'h0, 6'h00};
      rows[2] = {8'hCC, 8'h00, 8'h40, 8'h40, 8'h00, 1'h0, 6'h00};
      rows[3] = {8'h20, 8'h7F, 8'h7F, 8'h40, 8'h00, 1'h0, 6'h00};
      rows[4] = {8'hC8, 8'h00, 8'h40, 8'h7F, 8'h00, 1'h0, 6'h00};
      rows[5] = {8'hDC, 8'h00, 8'hC0, 8'h7F, 8'h00, 1'h0, 6'h00};
      rows[6] = {8'h30, 8'h40, 8'h00, 8'h7F, 8'h20, 1'h1, 6'h00};
      rows[7] = {8'hD8, 8'h00, 8'h7F, 8'h00, 8'h20, 1'h0, 6'h00};
      rows[8] = {8'h21, 8'h7F, 8'h7F, 8'h00, 8'h20, 1'h0, 6'h00};
      rows[9] = {8'h44, 8'h00, 8'hFE, 8'h00, 8'h40, 1'h0, 6'h00};
      rows[10] = {8'h54, 8'h00, 8'h81, 8'h00, 8'h40, 1'h0, 6'h00};
      rows[11] = {8'h74, 8'h00, 8'h01, 8'h00, 8'h40, 1'h0, 6'h00};
      rows[12] = {8'h64, 8'h00, 8'h7F, 8'h00, 8'h40, 1'h0, 6'h00};
      rows[13] = {8'h07, 8'h00, 8'h7F, 8'h40, 8'h40, 1'h0, 6'h00};
      rows[14] = {8'hCC, 8'h00, 8'h7F, 8'h7F, 8'h40, 1'h0, 6'h00};
      rows[15] = {8'h0E, 8'h00, 8'h7F, 8'h40, 8'h7F, 1'h0, 6'h00};
      rows[16] = {8'h20, 8'h80, 8'h80, 8'h40, 8'h7F, 1'h0, 6'h00};
      rows[17] = {8'hCC, 8'h00, 8'h80, 8'h80, 8'h7F, 1'h0, 6'h00};
      rows[18] = {8'h0E, 8'h00, 8'h80, 8'h40, 8'h80, 1'h0, 6'h00};
      rows[19] = {8'h2E, 8'h00, 8'h80, 8'h40, 8'h80, 1'h0, 6'h10};
      rows[20] = {8'hEC, 8'h00, 8'hC0, 8'h40, 8'h00, 1'h0, 6'h10};
      rows[21] = {8'h2F, 8'h00, 8'hC0, 8'h40, 8'h00, 1'h0, 6'h30};
      repeat (4) @(posedge clk);
      chk("acc0", 8'h00, acc0_q);
      chk("status", 8'h00, status_q);
      chk("halt", 8'h00, {7'h00, halted_q});
      rst_b <= 1'b1;
      for (i = 0; i < 22; i = i + 1) begin
         issue(8'h7F, 8'h00);
         issue(rows[i][46:39], rows[i][38:31]);
         drain;
         chk("acc0", rows[i][30:23], acc0_q);
         chk("stack", rows[i][22:15], stack_top_q);
         chk("status", rows[i][14:7], status_q);
         chk("skip", {7'h00, rows[i][6]}, {7'h00, skip_seen});
         chk("ctl", {2'h0, rows[i][5:0]}, {2'h0, interrupt_enable_flag_q, shift_via_ext_q, user_flags_q});
      end
      m = 4'h0;
      for (i = 1; i < 5; i = i + 1) begin
         b = 4'h1 << (i - 1);
         issue(8'h7F, 8'h00);
         issue(8'h38 | i[7:0], 8'h00);
         drain;
         chk("pulse", {4'h0, m | b}, {4'h0, hi_seen});
         chk("user", {4'h0, m}, {4'h0, user_flags_q});
         m = m | b;
         issue(8'h7F, 8'h00);
         issue(8'h28 | i[7:0], 8'h00);
         drain;
         chk("user", {4'h0, m}, {4'h0, user_flags_q});
      end
      for (i = 1; i < 6; i = i + 1) begin
         issue(8'h20, i[7:0]);
         issue(8'hCC, 8'h00);
      end
      for (i = 0; i < 5; i = i + 1) begin
         issue(8'hD8, 8'h00);
         drain;
         chk("pull", (i < 4) ? 8'h05 - i[7:0] : 8'h00, acc0_q);
      end
      issue(8'h7F, 8'h00);
      issue(8'h00, 8'h00);
      cmd_ok <= 1'b0;
      repeat (12) @(posedge clk);
      chk("halt", 8'h01, {7'h00, halted_q});
      start_in <= 1'b1;
      repeat (2) @(posedge clk);
      start_in <= 1'b0;
      drain;
      chk("halt", 8'h00, {7'h00, halted_q});
      end_sim;
   end
endmodule
